// ---- design/icc_pkg.sv ----
// Package for the input-capture block: register map, field layout,
// capture modes, gating modes and reset values.
// Assumes a 16-bit register port and a single 40 MHz clock domain.
package icc_pkg;

    // ==========================================================
    // Register port and clock
    // ==========================================================
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CLK_MHZ = 40;
    typedef logic [ADDR_W-1:0] icc_addr_t;
    typedef logic [DATA_W-1:0] icc_word_t;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam icc_addr_t A_CTRL_LO = 4'h0;
    localparam icc_addr_t A_CTRL_HI = 4'h1;
    localparam icc_addr_t A_STAT_LO = 4'h2;
    localparam icc_addr_t A_TMR_LO = 4'h3;
    localparam icc_addr_t A_TMR_HI = 4'h4;
    localparam icc_addr_t A_CAP_LO = 4'h5;
    localparam icc_addr_t A_CAP_HI = 4'h6;
    localparam icc_addr_t A_INT_STAT = 4'h7;
    localparam icc_addr_t A_INT_MASK = 4'h8;

    // ==========================================================
    // capture_control_low fields
    // ==========================================================
    localparam int unsigned CL_MOD_LSB = 0;
    localparam int unsigned CL_MOD_W = 4;
    localparam int unsigned CL_SEL = 4;
    localparam int unsigned CL_WIDE = 5;
    localparam icc_word_t CL_WR_MASK = 16'h003F;
    localparam icc_word_t CL_RST = 16'h0000;

    // ==========================================================
    // capture_control_high fields
    // ==========================================================
    localparam int unsigned CH_GATE_LSB = 0;
    localparam int unsigned CH_TRIGGERED_OPERATION_ENABLE = 2;
    localparam int unsigned CH_INTSRC = 3;
    localparam icc_word_t CH_WR_MASK = 16'h000F;
    localparam icc_word_t CH_RST = 16'h0000;

    // ==========================================================
    // capture_status_low fields
    // ==========================================================
    localparam int unsigned ST_ARM = 10;
    localparam int unsigned ST_TRIG = 7;
    localparam int unsigned ST_TRIGGER_SET_REQUEST = 6;
    localparam int unsigned ST_TRIGGER_CLEAR_REQUEST = 5;
    localparam int unsigned ST_AUTO_SHUTDOWN_FLAG = 4;
    localparam int unsigned ST_SINGLE_EDGE_COMPARE_FLAG = 3;
    localparam int unsigned ST_DIS = 2;
    localparam int unsigned ST_OV = 1;
    localparam int unsigned ST_BNE = 0;

    // ==========================================================
    // Interrupt status and mask layout
    // ==========================================================
    localparam int unsigned INT_W = 2;
    localparam int unsigned INT_CAP = 0;
    localparam int unsigned INT_OV = 1;

    // ==========================================================
    // Modes and prescaler limits
    // ==========================================================
    typedef enum logic [3:0] {
        MD_ANY = 4'h0,
        MD_RISE = 4'h1,
        MD_FALL = 4'h2,
        MD_BOTH = 4'h3,
        MD_RISE4 = 4'h4,
        MD_RISE16 = 4'h5
    } icc_mode_e;

    typedef enum logic [1:0] {
        GT_OFF = 2'h0,
        GT_ONE_A = 2'h1,
        GT_ONE_B = 2'h2,
        GT_RSV = 2'h3
    } icc_gate_e;

    localparam logic [3:0] PRE4_LAST = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;

endpackage

// ---- design/icc_mem_if.sv ----
// Interface between the capture controller and its FIFO memory.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface icc_mem_if #(
    parameter int W = 32,
    parameter int AW = 2
) ();
    logic we;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0] rdata;

    // Controller side
    modport ctl (output we, output waddr, output wdata, output raddr,
        input rdata);
    // Memory side
    modport mem (input we, input waddr, input wdata, input raddr,
        output rdata);
endinterface

// ---- design/icc_fifo_mem.sv ----
// Capture FIFO storage: one write port, one read port, registered read.
// Assumes the controller keeps the pointers; a read of the entry being
// written in the same cycle returns the new word.
`timescale 1ns/1ps
module icc_fifo_mem #(
    parameter int W = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Controller link
    icc_mem_if.mem m
);
    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] rd_ff;

    // ==========================================================
    // Elaboration check
    // ==========================================================
    generate
        if (DEPTH < 2)
        begin : g_bad_depth
            $error("DEPTH must be at least 2");
        end
    endgenerate

    // ==========================================================
    // Storage and registered read with write-through
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (m.we)
        begin
            mem_ff[m.waddr] <= m.wdata;
        end
    end

    // Read register follows the next head entry
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rd_ff <= '0;
        end
        else if (m.we && (m.waddr == m.raddr))
        begin
            rd_ff <= m.wdata;
        end
        else
        begin
            rd_ff <= mem_ff[m.raddr];
        end
    end

    assign m.rdata = rd_ff;
endmodule

// ---- design/icc_capture.sv ----
// Input-capture block: free-running capture timer, edge selection,
// prescaler, one-shot gate, capture FIFO, register port and interrupt.
// Assumes a single clock, a synchronous active-low reset and a register
// master that never issues read and write strobes together.
//
// Summary of operation
// - A pin or internal trigger event latches the capture timer value.
// - The capture timer is synchronous, counts up, 16 or 32 bits wide.
// - Every capture event pushes the latched timer value into the FIFO unless it is full.
// - Software reads the running count through timer low/high registers.
// - Capture works only while the capture select bit is set.
// - Operating select field and wide count bit choose the mode.
// - Mode 0000 captures on every edge of either polarity.
// - Wide bit clear captures 16 bits; set runs and captures 32 bits.
// - Mode 0001 captures on every rising edge.
// - Mode 0010 captures on every falling edge.
// - Mode 0011 captures on every rising and every falling edge.
// - Mode 0100 captures once per four rising edges via a prescaler.
// - Mode 0101 captures once per sixteen rising edges.
`timescale 1ns/1ps
module icc_capture
    import icc_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int TMR_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire icc_addr_t addr,
    input wire icc_word_t wdata,
    input wire logic wr,
    input wire logic rd,
    output icc_word_t rdata,
    // Event sources
    input wire logic capture_input_pin,
    input wire logic int_trig,
    // Interrupt
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int HALF = TMR_W / 2;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    generate
        if ((DEPTH < 2) || ((1 << PW) != DEPTH))
        begin : g_bad_depth
            $error("DEPTH must be a power of two of at least 2");
        end
        if (TMR_W != 2 * DATA_W)
        begin : g_bad_width
            $error("TMR_W must be twice the register width");
        end
        if (INT_W > DATA_W)
        begin : g_bad_int
            $error("interrupt layout wider than a register");
        end
    endgenerate

    typedef struct packed {
        logic [2:0] pin_sync;
        icc_word_t ctrl_lo;
        icc_word_t ctrl_hi;
        logic trig_run;
        logic dis;
        logic ov;
        logic gate_armed;
        logic [3:0] pre_cnt;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] tmr_view;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic irq;
        icc_word_t rdata;
    } icc_state_s;

    icc_state_s s_ff;
    icc_state_s nxt_s;

    icc_mem_if #(.W(TMR_W), .AW(PW)) mif ();

    // ==========================================================
    // Capture FIFO memory
    // ==========================================================
    icc_fifo_mem #(.W(TMR_W), .DEPTH(DEPTH)) u_mem (
        .clk(clk),
        .nrst(nrst),
        .m(mif)
    );

    // Decoded controls and events
    logic enable;
    logic wide;
    logic triggered_operation_enable;
    logic running;

    // Edges seen on the synchronised pin
    logic rise;
    logic fall;

    // Event path from source to FIFO
    logic pin_evt;
    logic src_evt;
    logic gated;
    logic evt;

    // FIFO control
    logic full;
    logic push;
    logic ovf_evt;
    logic pop;

    // Register port decode, captured word and mode decode
    logic wr_stat;
    logic [TMR_W-1:0] cap_val;
    icc_mode_e mode;
    icc_gate_e gate;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        nxt_s = s_ff;
        mode = icc_mode_e'(s_ff.ctrl_lo[CL_MOD_LSB +: CL_MOD_W]);
        gate = icc_gate_e'(s_ff.ctrl_hi[CH_GATE_LSB +: $bits(icc_gate_e)]);
        enable = s_ff.ctrl_lo[CL_SEL];
        wide = s_ff.ctrl_lo[CL_WIDE];
        triggered_operation_enable = s_ff.ctrl_hi[CH_TRIGGERED_OPERATION_ENABLE];
        wr_stat = wr && (addr == A_STAT_LO);
        pin_evt = 1'b0;

        // Pin synchroniser, stage 0 feeds stage 1 only
        nxt_s.pin_sync = {s_ff.pin_sync[1:0], capture_input_pin};
        rise = s_ff.pin_sync[1] & ~s_ff.pin_sync[2];
        fall = ~s_ff.pin_sync[1] & s_ff.pin_sync[2];

        // Trigger requests: set wins if both written at once
        if (wr_stat && wdata[ST_TRIGGER_CLEAR_REQUEST] && triggered_operation_enable)
        begin
            nxt_s.trig_run = 1'b0;
        end
        if (wr_stat && wdata[ST_TRIGGER_SET_REQUEST] && triggered_operation_enable)
        begin
            nxt_s.trig_run = 1'b1;
        end
        // Timer runs when enabled and, in triggered operation, once set
        running = enable && (!triggered_operation_enable || s_ff.trig_run);

        // Capture timer, held at zero while not running
        if (!running)
        begin
            nxt_s.tmr = '0;
        end
        else if (wide)
        begin
            nxt_s.tmr = s_ff.tmr + 1'b1;
        end
        else
        begin
            nxt_s.tmr = {{HALF{1'b0}}, s_ff.tmr[HALF-1:0] + 1'b1};
        end
        // Captured word is the count before this cycle's step
        cap_val = wide ? s_ff.tmr : {{HALF{1'b0}}, s_ff.tmr[HALF-1:0]};
        nxt_s.tmr_view = cap_val;

        // Edge selection and prescaler
        case (mode)
            MD_ANY: pin_evt = rise | fall;
            MD_RISE: pin_evt = rise;
            MD_FALL: pin_evt = fall;
            MD_BOTH: pin_evt = rise | fall;
            MD_RISE4:
            begin
                if (rise)
                begin
                    pin_evt = (s_ff.pre_cnt == PRE4_LAST);
                    nxt_s.pre_cnt = pin_evt ? '0 : s_ff.pre_cnt + 1'b1;
                end
            end
            MD_RISE16:
            begin
                if (rise)
                begin
                    pin_evt = (s_ff.pre_cnt == PRE16_LAST);
                    nxt_s.pre_cnt = pin_evt ? '0 : s_ff.pre_cnt + 1'b1;
                end
            end
            default: pin_evt = 1'b0;
        endcase
        // Prescaler restarts whenever it is not in use
        if (!enable || (mode != MD_RISE4 && mode != MD_RISE16))
        begin
            nxt_s.pre_cnt = '0;
        end

        // Event source: internal trigger or enabled pin edges
        src_evt = s_ff.ctrl_hi[CH_INTSRC] ? int_trig
            : (pin_evt && !s_ff.dis);

        // One-shot gate: an armed gate passes exactly one event
        gated = (gate == GT_ONE_A) || (gate == GT_ONE_B);
        evt = enable && src_evt && (!gated || s_ff.gate_armed);
        if (!gated || evt)
        begin
            nxt_s.gate_armed = 1'b0;
        end
        if (wr_stat && wdata[ST_ARM] && gated)
        begin
            nxt_s.gate_armed = 1'b1;
        end

        // FIFO push, pop and overflow
        full = (s_ff.count == (PW + 1)'(DEPTH));
        push = evt && !full;
        ovf_evt = evt && full;
        pop = rd && (addr == A_CAP_HI) && (s_ff.count != '0);
        // Read address runs one ahead on a pop, so the registered head
        // already holds the next entry when software asks for it
        mif.we = push;
        mif.waddr = s_ff.wr_ptr;
        mif.wdata = cap_val;
        mif.raddr = pop ? s_ff.rd_ptr + 1'b1 : s_ff.rd_ptr;
        // Pointers and occupancy
        if (push)
        begin
            nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_s.count = s_ff.count + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_s.count = s_ff.count - 1'b1;
        end

        // Clearable status: write zero clears, hardware set wins
        if (wr_stat && !wdata[ST_OV])
        begin
            nxt_s.ov = 1'b0;
        end
        if (wr_stat && !wdata[ST_DIS])
        begin
            nxt_s.dis = 1'b0;
        end
        if (ovf_evt)
        begin
            nxt_s.ov = 1'b1;
            nxt_s.dis = 1'b1;
        end

        // Control registers
        if (wr && (addr == A_CTRL_LO))
        begin
            nxt_s.ctrl_lo = wdata & CL_WR_MASK;
        end
        if (wr && (addr == A_CTRL_HI))
        begin
            nxt_s.ctrl_hi = wdata & CH_WR_MASK;
        end

        // Interrupt status: write one clears, new event wins
        if (wr && (addr == A_INT_STAT))
        begin
            nxt_s.int_stat = s_ff.int_stat & ~wdata[INT_W-1:0];
        end
        if (wr && (addr == A_INT_MASK))
        begin
            nxt_s.int_mask = wdata[INT_W-1:0];
        end
        if (evt)
        begin
            nxt_s.int_stat[INT_CAP] = 1'b1;
        end
        if (ovf_evt)
        begin
            nxt_s.int_stat[INT_OV] = 1'b1;
        end
        nxt_s.irq = |(nxt_s.int_stat & nxt_s.int_mask);

        // Read data, valid only in the cycle after the strobe
        nxt_s.rdata = '0;
        if (rd)
        begin
            case (addr)
                A_CTRL_LO: nxt_s.rdata = s_ff.ctrl_lo;
                A_CTRL_HI: nxt_s.rdata = s_ff.ctrl_hi;
                A_STAT_LO:
                begin
                    nxt_s.rdata[ST_TRIG] = running;
                    nxt_s.rdata[ST_DIS] = s_ff.dis;
                    nxt_s.rdata[ST_OV] = s_ff.ov;
                    nxt_s.rdata[ST_BNE] = (s_ff.count != '0);
                    // Strobes and unused event bits always read zero
                    nxt_s.rdata[ST_ARM] = 1'b0;
                    nxt_s.rdata[ST_TRIGGER_SET_REQUEST] = 1'b0;
                    nxt_s.rdata[ST_TRIGGER_CLEAR_REQUEST] = 1'b0;
                    nxt_s.rdata[ST_AUTO_SHUTDOWN_FLAG] = 1'b0;
                    nxt_s.rdata[ST_SINGLE_EDGE_COMPARE_FLAG] = 1'b0;
                end
                A_TMR_LO: nxt_s.rdata = s_ff.tmr_view[HALF-1:0];
                A_TMR_HI: nxt_s.rdata = s_ff.tmr_view[TMR_W-1:HALF];
                // Capture words come from the registered FIFO head
                A_CAP_LO: nxt_s.rdata = mif.rdata[HALF-1:0];
                A_CAP_HI: nxt_s.rdata = mif.rdata[TMR_W-1:HALF];
                A_INT_STAT: nxt_s.rdata[INT_W-1:0] = s_ff.int_stat;
                A_INT_MASK: nxt_s.rdata[INT_W-1:0] = s_ff.int_mask;
                default: nxt_s.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign rdata = s_ff.rdata;
    assign irq = s_ff.irq;
endmodule

// ---- verif/icc_edge_src.sv ----
// Model of the edge source that drives the capture input.
// Assumes a push-pull driver on the block clock; idle level low.
`timescale 1ns/1ps
module icc_edge_src (
    // Clock
    input wire logic clk,
    // Source line
    output logic pin
);
    initial pin = 1'b0;
    // Whole pulses, each half held for half cycles
    task automatic pulses(input int n, input int half);
        repeat (n)
        begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (half) @(posedge clk);
            pin <= 1'b0;
            repeat (half - 1) @(posedge clk);
        end
    endtask
endmodule

// ---- verif/icc_capture_monitor.sv ----
// Checker for the input-capture block, bound to its top module.
// Assumes it sees the top-level ports only.
`timescale 1ns/1ps
module icc_capture_monitor
    import icc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire icc_addr_t addr,
    input wire icc_word_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire icc_word_t rdata,
    // Events and interrupt
    input wire logic capture_input_pin,
    input wire logic int_trig,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    icc_word_t ctrl_ff, chi_ff, mask_ff;
    logic [2:0] quiet_ff;
    // ==========================================================
    // Shadow copies of the control and mask registers
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl_ff <= '0;
            chi_ff <= '0;
            mask_ff <= '0;
            quiet_ff <= 3'h0;
        end
        else
        begin
            if (wr && addr == A_CTRL_LO)
                ctrl_ff <= wdata & CL_WR_MASK;
            if (wr && addr == A_CTRL_HI)
                chi_ff <= wdata & CH_WR_MASK;
            if (wr && addr == A_INT_MASK)
                mask_ff <= wdata;
            if (wr && (addr == A_CTRL_LO || addr == A_CTRL_HI))
                quiet_ff <= 3'h0;
            else if (quiet_ff != 3'h7)
                quiet_ff <= quiet_ff + 3'h1;
        end
    end
    // ==========================================================
    // Assertions
    // ==========================================================
    read_idle_zero_a: assert property (
        !$past(rd) |-> rdata == '0) else $error("stray read data");
    ctrl_readback_a: assert property (
        $past(rd && addr == A_CTRL_LO) |-> rdata == ctrl_ff)
        else $error("control readback wrong");
    stat_strobes_zero_a: assert property (
        $past(rd && addr == A_STAT_LO) |-> {rdata[15:8], rdata[6:3]} == 12'h000)
        else $error("status strobe bits read nonzero");
    unmapped_zero_a: assert property (
        $past(rd && addr > A_INT_MASK) |-> rdata == '0)
        else $error("unmapped read nonzero");
    masked_irq_low_a: assert property (
        mask_ff == '0 && $past(mask_ff) == '0 |-> !irq)
        else $error("interrupt while fully masked");
    hi_half_zero_a: assert property (
        $past(rd && addr == A_TMR_HI) && !ctrl_ff[CL_WIDE] && quiet_ff == 3'h7
        |-> rdata == '0) else $error("upper timer half nonzero");
    timer_steps_a: assert property (
        $past(rd && addr == A_TMR_LO) && $past(rd && addr == A_TMR_LO, 2)
        && ctrl_ff[CL_SEL] && !chi_ff[CH_TRIGGERED_OPERATION_ENABLE] && quiet_ff == 3'h7
        |-> rdata == 16'($past(rdata) + 16'h0001))
        else $error("timer did not step by one");
    timer_held_a: assert property (
        $past(rd && addr == A_TMR_LO) && !ctrl_ff[CL_SEL] && quiet_ff == 3'h7
        |-> rdata == '0) else $error("idle timer not held at zero");
endmodule

bind icc_capture icc_capture_monitor mon (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .capture_input_pin(capture_input_pin), .int_trig(int_trig), .irq(irq));

// ---- verif/icc_capture_test.sv ----
// Self-checking bench for the input-capture block.
// Assumes the edge source model and the bound checker.
`timescale 1ns/1ps
module icc_capture_test
    import icc_pkg::*;
;
    logic clk, nrst, wr, rd, int_trig, irq, capture_input_pin;
    icc_addr_t addr;
    icc_word_t wdata, rdata, v;
    int fail_count, checks_done, n;
    int pul[6] = '{8, 8, 8, 8, 8, 16};
    int exp_n[6] = '{16, 8, 8, 16, 2, 1};
    // ==========================================================
    // Clock, design and edge source
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    icc_capture #(.DEPTH(16), .TMR_W(32)) uut (.clk(clk), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .capture_input_pin(capture_input_pin), .int_trig(int_trig), .irq(irq));
    icc_edge_src src (.clk(clk), .pin(capture_input_pin));
    // ==========================================================
    // Bus and check tasks
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input icc_addr_t a, input icc_word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input icc_addr_t a, output icc_word_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Pops every entry, counting them and checking their order
    task automatic drain(output int cnt);
        icc_word_t s, lo, hi, prev;
        cnt = 0;
        prev = '0;
        repeat (40)
        begin
            rreg(A_STAT_LO, s);
            if (s[ST_BNE] === 1'b1)
            begin
                rreg(A_CAP_LO, lo);
                rreg(A_CAP_HI, hi);
                chk(hi, 16'h0000);
                if (cnt > 0) chk(lo > prev, 1'b1);
                prev = lo;
                cnt++;
            end
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // Watchdog
    // ==========================================================
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        int_trig = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 10; a++)
        begin
            if (a != 5 && a != 6) rreg(icc_addr_t'(a), v);
            if (a != 5 && a != 6) chk(v, 16'h0000);
        end
        wreg(4'h9, 16'hFFFF);
        rreg(4'h9, v);
        chk(v, 16'h0000);
        wreg(A_CTRL_LO, 16'hFFFF);
        rreg(A_CTRL_LO, v);
        chk(v, CL_WR_MASK);
        $display("end of reset test");
        for (int m = 0; m < 6; m++)
        begin
            wreg(A_CTRL_LO, 16'h0010 | 16'(m));
            src.pulses(pul[m], 2 + m % 2);
            repeat (6) @(posedge clk);
            drain(n);
            chk(n, exp_n[m]);
        end
        wreg(A_CTRL_LO, 16'h0001);
        src.pulses(2, 2);
        drain(n);
        chk(n, 0);
        $display("end of mode test");
        wreg(A_CTRL_LO, 16'h0011);
        wreg(A_INT_MASK, 16'h0003);
        src.pulses(17, 2);
        repeat (6) @(posedge clk);
        rreg(A_STAT_LO, v);
        chk(v[2:0], 3'h7);
        chk(irq, 1'b1);
        drain(n);
        chk(n, 16);
        src.pulses(2, 2);
        drain(n);
        chk(n, 0);
        rreg(A_STAT_LO, v);
        chk(v[ST_OV], 1'b1);
        wreg(A_STAT_LO, 16'h0000);
        src.pulses(1, 2);
        repeat (6) @(posedge clk);
        drain(n);
        chk(n, 1);
        @(posedge clk);
        addr <= A_TMR_LO;
        rd <= 1'b1;
        repeat (2) @(posedge clk);
        rd <= 1'b0;
        wreg(A_INT_MASK, 16'h0000);
        #1 chk(irq, 1'b0);
        wreg(A_INT_MASK, 16'h0003);
        #1 chk(irq, 1'b1);
        wreg(A_INT_STAT, 16'h0003);
        #1 chk(irq, 1'b0);
        $display("end of overflow test");
        wreg(A_CTRL_HI, 16'h0004);
        repeat (3) @(posedge clk);
        rreg(A_TMR_LO, v);
        chk(v, 16'h0000);
        wreg(A_STAT_LO, 16'h0040);
        repeat (4) @(posedge clk);
        rreg(A_STAT_LO, v);
        chk(v[7:5], 3'h4);
        rreg(A_TMR_LO, v);
        chk(v != 16'h0000, 1'b1);
        wreg(A_STAT_LO, 16'h0020);
        repeat (4) @(posedge clk);
        rreg(A_TMR_LO, v);
        chk(v, 16'h0000);
        $display("end of trigger test");
        for (int g = 1; g < 3; g++)
        begin
            wreg(A_CTRL_HI, 16'(g));
            src.pulses(2, 2);
            drain(n);
            chk(n, 0);
            wreg(A_STAT_LO, 16'h0400);
            rreg(A_STAT_LO, v);
            chk(v[ST_ARM], 1'b0);
            src.pulses(3, 2);
            repeat (6) @(posedge clk);
            drain(n);
            chk(n, 1);
        end
        wreg(A_CTRL_HI, 16'h0008);
        wreg(A_CTRL_LO, 16'h0010);
        @(posedge clk);
        int_trig <= 1'b1;
        @(posedge clk);
        int_trig <= 1'b0;
        repeat (4) @(posedge clk);
        rreg(A_STAT_LO, v);
        chk(v[ST_BNE], 1'b1);
        $display("end of gate test");
        final_report();
    end
endmodule
